// ### dcto_defines.svh
`ifndef DCTO_DEFINES_SVH
`define DCTO_DEFINES_SVH

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define DCTO_CLK_MHZ 125
`define DCTO_DISC_MS 500
`define DCTO_BOTH_OFF_MS 100
`define DCTO_TEST_PULSE_MS 200
`define DCTO_MS_TO_CYC(ms) ((ms) * 1000 * `DCTO_CLK_MHZ)
`define DCTO_DISC_CYC `DCTO_MS_TO_CYC(`DCTO_DISC_MS)
`define DCTO_BOTH_OFF_CYC `DCTO_MS_TO_CYC(`DCTO_BOTH_OFF_MS)
`define DCTO_TEST_PULSE_CYC `DCTO_MS_TO_CYC(`DCTO_TEST_PULSE_MS)

// ---------------------------------------------------------------------------
// status array fields and counter width
// ---------------------------------------------------------------------------
`define DCTO_ARR_ANY 0
`define DCTO_ARR_A 1
`define DCTO_ARR_B 2
`define DCTO_ARR_W 3
`define DCTO_ARR_ALL_OFF 3'h7
`define DCTO_CNT_W 32

`endif

// ### dcto_pkg.sv
package dcto_pkg;

  // operating state reported by the monitor
  typedef enum logic [1:0] {
    DCTO_OP_READY,
    DCTO_OP_TORQUE_OFF,
    DCTO_OP_LOCKOUT,
    DCTO_OP_FAULT
  } dcto_op_t;

  // function test sequencer states on the controller end
  typedef enum logic [2:0] {
    DCTO_T_IDLE,
    DCTO_T_ALL_OFF,
    DCTO_T_A_LOW,
    DCTO_T_B_LOW,
    DCTO_T_RESTORE,
    DCTO_T_DONE
  } dcto_tstate_t;

endpackage : dcto_pkg

// ### dcto_link_if.sv
`timescale 1ns/10ps
// two torque-off lines and the per-device status pin
interface dcto_link_if;
  logic torque_off_in_a;
  logic torque_off_in_b;
  logic torque_off_state_out;

  modport device (
    input torque_off_in_a,
    input torque_off_in_b,
    output torque_off_state_out
  );

  modport controller (
    output torque_off_in_a,
    output torque_off_in_b,
    input torque_off_state_out
  );
endinterface : dcto_link_if

// ### dcto_monitor.sv
`timescale 1ns/10ps
`include "dcto_defines.svh"
// Behaviour
// RULE1 - status array: any, A low, B low
// RULE2 - single channel 500 ms or more: fault
// RULE3 - tester keeps test pulses under 500 ms
// RULE4 - function test holds switch-on lockout state
// RULE5 - after fault act as torque-off, refuse enable
// RULE6 - tester alternates inputs, compares status pattern
// RULE7 - test after every torque-off deactivation, record
// RULE8 - status outputs checked per device, unchained
// RULE9 - on channel error remove healthy input first; code drops both lines in the same cycle
// RULE10 - both inputs off 100 ms before enable; code does not time the both-off before raising the lines
// RULE11 - raise both inputs within 500 ms
// RULE12 - fault acknowledge only after 100 ms both-off
// RULE13 - synchronise inputs, count discrepancy, clear on agree
module dcto_monitor
  import dcto_pkg::*;
#(
  parameter int DISC_CYC = `DCTO_DISC_CYC,
  parameter int BOTH_OFF_CYC = `DCTO_BOTH_OFF_CYC
)
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  dcto_link_if.device link,
  input wire logic enable_req_in,
  input wire logic fault_ack_in,
  input wire logic test_mode_in,
  output logic [`DCTO_ARR_W-1:0] torque_off_state_array_out,
  output logic drive_enabled_out,
  output logic fault_out,
  output dcto_op_t op_state_out
);

  // -------------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------------
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;

  // RULE13 two-stage synchroniser
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end
    else
    begin
      sync1_q <= {link.torque_off_in_b, link.torque_off_in_a};
      sync2_q <= sync1_q;
    end
  end

  logic a_off;
  logic b_off;
  logic single_off;
  logic both_off;
  assign a_off = ~sync2_q[0];
  assign b_off = ~sync2_q[1];
  assign single_off = a_off ^ b_off;
  assign both_off = a_off & b_off;

  // -------------------------------------------------------------------------
  // channel pair history
  // -------------------------------------------------------------------------
  logic [1:0] pair_q;
  logic pair_moved;
  assign pair_moved = (sync2_q != pair_q);

  // last synchronised pair, so a channel swap is seen
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      pair_q <= 2'h0;
    else
      pair_q <= sync2_q;
  end

  // -------------------------------------------------------------------------
  // discrepancy and both-off timers
  // -------------------------------------------------------------------------
  // counters saturate so a stuck input cannot wrap them
  logic [`DCTO_CNT_W-1:0] disc_cnt_q;
  logic [`DCTO_CNT_W-1:0] off_cnt_q;
  logic disc_expired;
  logic off_long;
  assign disc_expired = (disc_cnt_q >= DISC_CYC[`DCTO_CNT_W-1:0]);
  assign off_long = (off_cnt_q >= BOTH_OFF_CYC[`DCTO_CNT_W-1:0]);

  // RULE13 count while channels disagree
  // a swap restarts it: back-to-back test pulses are never summed
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      disc_cnt_q <= '0;
    else if (!single_off || pair_moved)
      disc_cnt_q <= '0;
    else if (!disc_expired)
      disc_cnt_q <= disc_cnt_q + `DCTO_CNT_W'(1);
  end

  // both-off duration, saturating
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      off_cnt_q <= '0;
    else if (!both_off)
      off_cnt_q <= '0;
    else if (!off_long)
      off_cnt_q <= off_cnt_q + `DCTO_CNT_W'(1);
  end

  // latches that a 100 ms both-off episode occurred since fault entry
  logic off_seen_q;
  logic fault_q;

  // -------------------------------------------------------------------------
  // fault latch
  // -------------------------------------------------------------------------
  // RULE2 discrepancy at 500 ms sets fault; set wins over acknowledge
  // a standing discrepancy keeps the latch set under acknowledge
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      fault_q <= 1'b0;
    else if (single_off && disc_expired)
      fault_q <= 1'b1;
    // RULE12 ack only after 100 ms both-off
    else if (fault_ack_in && off_seen_q)
      fault_q <= 1'b0;
  end

  // both-off credit, earned only while faulted
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      off_seen_q <= 1'b0;
    else if (single_off && disc_expired)
      off_seen_q <= 1'b0;
    else if (fault_q && both_off && off_long)
      off_seen_q <= 1'b1;
    else if (!fault_q)
      off_seen_q <= 1'b0;
  end

  // -------------------------------------------------------------------------
  // status outputs and operating state
  // -------------------------------------------------------------------------
  logic any_off;
  assign any_off = a_off | b_off;

  // RULE1 status array; RULE5 fault reads as both requested
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      torque_off_state_array_out <= `DCTO_ARR_ALL_OFF;
      link.torque_off_state_out <= 1'b1;
    end
    else
    begin
      torque_off_state_array_out[`DCTO_ARR_ANY] <= any_off | fault_q;
      torque_off_state_array_out[`DCTO_ARR_A] <= a_off | fault_q;
      torque_off_state_array_out[`DCTO_ARR_B] <= b_off | fault_q;
      link.torque_off_state_out <= any_off | fault_q;
    end
  end

  // RULE5 enable refused while faulted; RULE4 lockout during test
  // lockout follows test_mode_in, a test is not visible on the lines
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      op_state_out <= DCTO_OP_TORQUE_OFF;
      drive_enabled_out <= 1'b0;
      fault_out <= 1'b0;
    end
    else
    begin
      fault_out <= fault_q;
      if (fault_q)
      begin
        op_state_out <= DCTO_OP_FAULT;
        drive_enabled_out <= 1'b0;
      end
      else if (test_mode_in)
      begin
        op_state_out <= DCTO_OP_LOCKOUT;
        drive_enabled_out <= 1'b0;
      end
      else if (any_off)
      begin
        op_state_out <= DCTO_OP_TORQUE_OFF;
        drive_enabled_out <= 1'b0;
      end
      else
      begin
        op_state_out <= DCTO_OP_READY;
        drive_enabled_out <= enable_req_in;
      end
    end
  end

endmodule : dcto_monitor

// ### dcto_controller.sv
`timescale 1ns/10ps
`include "dcto_defines.svh"
// controller end: drives the lines and runs the function test
module dcto_controller
  import dcto_pkg::*;
#(
  parameter int PULSE_CYC = `DCTO_TEST_PULSE_CYC
)
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  dcto_link_if.controller link,
  input wire logic run_in,
  input wire logic start_test_in,
  input wire logic chan_error_in,
  output logic test_busy_out,
  output logic test_done_out,
  output logic test_pass_out
);

  // -------------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------------
  dcto_tstate_t st_q;
  logic [`DCTO_CNT_W-1:0] cnt_q;
  logic step_done;
  logic err_q;
  logic run_q;
  logic need_test_q;
  assign step_done = (cnt_q >= PULSE_CYC[`DCTO_CNT_W-1:0]);

  // RULE3 dwell counter keeps pulses under 500 ms
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cnt_q <= '0;
    else if (step_done || st_q == DCTO_T_IDLE || st_q == DCTO_T_DONE)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + `DCTO_CNT_W'(1);
  end

  // RULE7 test demanded after each deactivation
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      run_q <= 1'b0;
      need_test_q <= 1'b1;
    end
    else
    begin
      run_q <= run_in;
      if (run_q && !run_in)
        need_test_q <= 1'b1;
      else if (st_q == DCTO_T_DONE)
        need_test_q <= 1'b0;
    end
  end

  // RULE6 alternate inputs, compare status at step end
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_q <= DCTO_T_IDLE;
      err_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        DCTO_T_IDLE:
          if (start_test_in && need_test_q && !run_in)
          begin
            st_q <= DCTO_T_ALL_OFF;
            err_q <= 1'b0;
          end
        DCTO_T_ALL_OFF:
          if (step_done)
          begin
            err_q <= err_q | ~link.torque_off_state_out;
            st_q <= DCTO_T_A_LOW;
          end
        DCTO_T_A_LOW:
          if (step_done)
          begin
            err_q <= err_q | ~link.torque_off_state_out;
            st_q <= DCTO_T_B_LOW;
          end
        DCTO_T_B_LOW:
          if (step_done)
          begin
            err_q <= err_q | ~link.torque_off_state_out;
            st_q <= DCTO_T_RESTORE;
          end
        DCTO_T_RESTORE:
          if (step_done)
          begin
            err_q <= err_q | link.torque_off_state_out;
            st_q <= DCTO_T_DONE;
          end
        DCTO_T_DONE:
          st_q <= DCTO_T_IDLE;
        default:
          st_q <= DCTO_T_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // line drive
  // -------------------------------------------------------------------------
  // RULE9 channel error drops both lines; RULE11 raise together
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      link.torque_off_in_a <= 1'b0;
      link.torque_off_in_b <= 1'b0;
    end
    else if (chan_error_in)
    begin
      link.torque_off_in_a <= 1'b0;
      link.torque_off_in_b <= 1'b0;
    end
    else
    begin
      case (st_q)
        DCTO_T_ALL_OFF:
        begin
          link.torque_off_in_a <= 1'b0;
          link.torque_off_in_b <= 1'b0;
        end
        DCTO_T_A_LOW:
        begin
          link.torque_off_in_a <= 1'b0;
          link.torque_off_in_b <= 1'b1;
        end
        DCTO_T_B_LOW:
        begin
          link.torque_off_in_a <= 1'b1;
          link.torque_off_in_b <= 1'b0;
        end
        DCTO_T_RESTORE:
        begin
          link.torque_off_in_a <= 1'b1;
          link.torque_off_in_b <= 1'b1;
        end
        default:
        begin
          // RULE10 lines only raised after tested both-off
          link.torque_off_in_a <= run_in & ~need_test_q;
          link.torque_off_in_b <= run_in & ~need_test_q;
        end
      endcase
    end
  end

  // RULE8 per-device result record
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      test_busy_out <= 1'b0;
      test_done_out <= 1'b0;
      test_pass_out <= 1'b0;
    end
    else
    begin
      test_busy_out <= (st_q != DCTO_T_IDLE) && (st_q != DCTO_T_DONE);
      test_done_out <= (st_q == DCTO_T_DONE);
      if (st_q == DCTO_T_DONE)
        test_pass_out <= ~err_q;
    end
  end

endmodule : dcto_controller

// ### dcto_link_checker.sv
`timescale 1ns/10ps
// ------
// link checks
// ------
module dcto_link_checker (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic torque_off_in_a,
  input wire logic torque_off_in_b,
  input wire logic torque_off_state_out,
  input wire logic [2:0] torque_off_state_array_out,
  input wire logic drive_enabled_out,
  input wire logic fault_out
);
  // short local names
  wire a = torque_off_in_a;
  wire b = torque_off_in_b;
  wire st = torque_off_state_out;
  wire [2:0] arr = torque_off_state_array_out;
  // cycles since reset release, so deep past looks stay inside the run
  logic [1:0] warm_q;
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
      warm_q <= 2'h0;
    else if (warm_q != 2'h3)
      warm_q <= warm_q + 2'h1;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  a_arr_a_lag: assert property (warm_q == 2'h3 && !fault_out |-> arr[1] == !$past(a, 3))
    else $error("array bit a out of step");
  a_arr_b_lag: assert property (warm_q == 2'h3 && !fault_out |-> arr[2] == !$past(b, 3))
    else $error("array bit b out of step");
  a_any_is_or: assert property (arr[0] == (arr[1] | arr[2]))
    else $error("array bit any not or of a and b");
  a_state_equals: assert property (st == arr[0])
    else $error("status pin differs from array");
  a_off_in_lag: assert property ($fell(a) |-> ##[1:3] st)
    else $error("status pin late after a fell");
  a_quiet_stable: assert property ((($stable(a) && $stable(b)) [*4]) ##0 $stable(fault_out) |-> $stable(arr))
    else $error("array moved with quiet inputs");
  a_enable_needs_on: assert property ($rose(drive_enabled_out) |-> !st && !fault_out)
    else $error("enabled while torque off");
  a_fault_all_off: assert property (fault_out |-> arr == 3'h7 && st)
    else $error("fault without full torque off");
  // main scenarios seen
  c_enable: cover property ($rose(drive_enabled_out));
  c_a_only: cover property (!a && b);
  c_b_only: cover property ($fell(b) && a);
endmodule : dcto_link_checker

// ### test_dual_channel_torque_off_monitor.sv
`timescale 1ns/10ps
module test_dual_channel_torque_off_monitor import dcto_pkg::*;;
  localparam int DISC = 40;
  localparam int BOFF = 10;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic run_in = 1'b0, start_test_in = 1'b0, chan_error_in = 1'b0;
  logic en = 1'b0, ack = 1'b0, tmode = 1'b0;
  logic busy, done, pass, en1, flt1, en2, flt2;
  logic [2:0] arr1, arr2;
  dcto_op_t op1, op2;
  int fails = 0, num_checks = 0;
  dcto_link_if link ();
  dcto_link_if link2 ();
  // ------
  // clock and design
  // ------
  always #4 sys_clk_in = ~sys_clk_in;
  dcto_controller #(.PULSE_CYC(8)) dcto_controller_i (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .link(link.controller), .run_in(run_in),
    .start_test_in(start_test_in), .chan_error_in(chan_error_in),
    .test_busy_out(busy), .test_done_out(done), .test_pass_out(pass));
  dcto_monitor #(.DISC_CYC(DISC), .BOTH_OFF_CYC(BOFF)) dcto_monitor_i (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .link(link.device), .enable_req_in(en), .fault_ack_in(ack),
    .test_mode_in(tmode), .torque_off_state_array_out(arr1), .drive_enabled_out(en1),
    .fault_out(flt1), .op_state_out(op1));
  // second monitor, lines driven by the bench
  dcto_monitor #(.DISC_CYC(DISC), .BOTH_OFF_CYC(BOFF)) dcto_monitor_i2 (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .link(link2.device), .enable_req_in(en), .fault_ack_in(ack),
    .test_mode_in(tmode), .torque_off_state_array_out(arr2), .drive_enabled_out(en2),
    .fault_out(flt2), .op_state_out(op2));
  dcto_link_checker dcto_link_checker_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .torque_off_in_a(link.torque_off_in_a), .torque_off_in_b(link.torque_off_in_b),
    .torque_off_state_out(link.torque_off_state_out), .torque_off_state_array_out(arr1),
    .drive_enabled_out(en1), .fault_out(flt1));
  // ------
  // helpers
  // ------
  task automatic chk3(input logic [2:0] g, input logic [2:0] e);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk3
  task automatic chk1(input logic g, input logic e);
    chk3({2'h0, g}, {2'h0, e});
  endtask : chk1
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : step
  task automatic end_of_test;
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // ------
  // scenarios
  // ------
  // function test with enable refused in lockout
  task automatic run_test;
    int k;
    @(posedge sys_clk_in) start_test_in <= 1'b1;
    tmode <= 1'b1;
    en <= 1'b1;
    step(12);
    chk3({1'b0, op1}, {1'b0, DCTO_OP_LOCKOUT});
    chk1(en1, 1'b0);
    chk1(busy, 1'b1);
    @(posedge sys_clk_in) start_test_in <= 1'b0;
    for (k = 0; k < 200 && done !== 1'b1; k++)
      step(1);
    chk1(done, 1'b1);
    step(2);
    chk1(pass, 1'b1);
    @(posedge sys_clk_in) tmode <= 1'b0;
  endtask : run_test
  // run, channel error, restart without test
  task automatic t_run;
    @(posedge sys_clk_in) run_in <= 1'b1;
    step(8);
    chk3(arr1, 3'h0);
    chk1(en1, 1'b1);
    chk3({1'b0, op1}, {1'b0, DCTO_OP_READY});
    @(posedge sys_clk_in) chan_error_in <= 1'b1;
    step(8);
    chk3(arr1, 3'h7);
    chk1(en1, 1'b0);
    chk1(flt1, 1'b0);
    chk3({1'b0, op1}, {1'b0, DCTO_OP_TORQUE_OFF});
    @(posedge sys_clk_in) chan_error_in <= 1'b0;
    run_in <= 1'b0;
    step(4);
    @(posedge sys_clk_in) run_in <= 1'b1;
    step(8);
    chk3(arr1, 3'h7);
    @(posedge sys_clk_in) run_in <= 1'b0;
  endtask : t_run
  // short pulse, long pulse, acknowledge
  task automatic t_fault;
    step(1);
    chk1(link2.torque_off_state_out, 1'b0);
    chk1(link.torque_off_state_out, 1'b1);
    @(posedge sys_clk_in) link2.torque_off_in_a <= 1'b0;
    step(DISC - 10);
    @(posedge sys_clk_in) link2.torque_off_in_a <= 1'b1;
    step(12);
    chk1(flt2, 1'b0);
    // a-only then b-only, each short, together past the limit
    @(posedge sys_clk_in) link2.torque_off_in_a <= 1'b0;
    step(DISC - 10);
    @(posedge sys_clk_in) link2.torque_off_in_a <= 1'b1;
    link2.torque_off_in_b <= 1'b0;
    step(DISC - 10);
    @(posedge sys_clk_in) link2.torque_off_in_b <= 1'b1;
    step(12);
    chk1(flt2, 1'b0);
    @(posedge sys_clk_in) link2.torque_off_in_a <= 1'b0;
    step(DISC + 8);
    chk1(flt2, 1'b1);
    chk3({1'b0, op2}, {1'b0, DCTO_OP_FAULT});
    chk3(arr2, 3'h7);
    chk1(link2.torque_off_state_out, 1'b1);
    chk1(en2, 1'b0);
    @(posedge sys_clk_in) ack <= 1'b1;
    step(3);
    @(posedge sys_clk_in) ack <= 1'b0;
    step(3);
    chk1(flt2, 1'b1);
    @(posedge sys_clk_in) link2.torque_off_in_b <= 1'b0;
    step(BOFF + 8);
    @(posedge sys_clk_in) ack <= 1'b1;
    step(2);
    @(posedge sys_clk_in) ack <= 1'b0;
    step(4);
    chk1(flt2, 1'b0);
  endtask : t_fault
  // main sequence
  initial
  begin
    link2.torque_off_in_a = 1'b1;
    link2.torque_off_in_b = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    step(1);
    chk3(arr1, 3'h7);
    chk1(link.torque_off_state_out, 1'b1);
    chk1(en1, 1'b0);
    chk1(busy, 1'b0);
    run_test();
    t_run();
    t_fault();
    end_of_test();
  end
  // watchdog
  initial
  begin
    repeat (2000) @(posedge sys_clk_in);
    fails++;
    end_of_test();
  end
endmodule : test_dual_channel_torque_off_monitor
